/* hdl/pfail_seq.sv */
// Module: power-fail supervisor, EEPROM save and reset request
// Assumes alert is asynchronous; supervisor resets this block via rst_b
`timescale 1ns/1ns
module pfail_seq
  import pfail_pkg::*;
#(
  parameter int RECHECK_CYCLES = RECHECK_CYC,
  parameter int SAVE_LIMIT_CYCLES = EE_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Supply board and supervisor
  input wire logic power_fail_alert,
  output logic reset_request_out,
  output logic printing_stop,
  output logic feed_motor_hold_n,
  // Printer status and settings source
  input wire logic printing,
  input wire logic [7:0] setting_data [SAVE_BYTES],
  // EEPROM port pins
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic ee_do
);
  pf_state_t state;
  logic alert_s1, alert_s2;
  logic [23:0] timer;
  logic [5:0] byte_idx;
  logic [7:0] save_buf [SAVE_BYTES];
  ee_link_if link ();

  // Alert synchroniser
  always_ff @(posedge clk_sys) begin
    alert_s1 <= power_fail_alert;
    alert_s2 <= alert_s1;
  end

  // Power-off sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: if (alert_s2) state <= printing ? ST_RECHECK : ST_SAVE;
        ST_RECHECK: if (timer == 24'(RECHECK_CYCLES - 1))
          state <= alert_s2 ? ST_SAVE : ST_RUN;
        ST_SAVE: state <= ST_SAVE_WAIT;
        ST_SAVE_WAIT: begin
          if (link.done && byte_idx == 6'(SAVE_BYTES - 1)) state <= ST_RESET;
          else if (link.done) state <= ST_SAVE;
          else if (timer == 24'(SAVE_LIMIT_CYCLES - 1)) state <= ST_RESET;
        end
        ST_RESET: state <= ST_HALT;
        ST_HALT: state <= ST_HALT;
        default: state <= ST_RUN;
      endcase
    end
  end

  // Recheck and save timeout timer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) timer <= '0;
    else if (state == ST_RUN || state == ST_SAVE) timer <= '0;
    else if (state == ST_RECHECK || state == ST_SAVE_WAIT) timer <= timer + 24'h1;
  end

  // Settings snapshot at the power-off decision
  always_ff @(posedge clk_sys) begin
    if (state == ST_RUN || state == ST_RECHECK) save_buf <= setting_data;
  end

  // Byte index through the save area
  always_ff @(posedge clk_sys) begin
    if (!rst_b || state == ST_RUN) byte_idx <= '0;
    else if (state == ST_SAVE_WAIT && link.done) byte_idx <= byte_idx + 6'h1;
  end

  // Writer request
  assign link.start = (state == ST_SAVE);
  assign link.addr = {1'b0, byte_idx};
  assign link.data = save_buf[byte_idx[4:0]];

  // Outputs; reset request high only after the save ends or a byte write times out
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reset_request_out <= 1'b0;
      printing_stop <= 1'b0;
    end else begin
      if (state == ST_RESET) reset_request_out <= 1'b1;
      if (state != ST_RUN) printing_stop <= 1'b1;
    end
  end

  // Feed motor hold is low while in reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) feed_motor_hold_n <= 1'b0;
    else feed_motor_hold_n <= ~reset_request_out;
  end

  // Serial EEPROM writer; inhibited in reset
  ee_writer u_writer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inhibit(reset_request_out),
    .link(link),
    .ee_cs(ee_cs),
    .ee_sk(ee_sk),
    .ee_di(ee_di),
    .ee_do(ee_do)
  );

  // Checks
  idle_alert_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_RUN && alert_s2 && !printing |=> state == ST_SAVE)
    else $error("idle alert did not start save");
  print_alert_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_RUN && alert_s2 && printing |=> state == ST_RECHECK ##1 printing_stop)
    else $error("print alert did not recheck");
  sync_path_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_RUN && !$past(alert_s1) |=> state != ST_RECHECK)
    else $error("alert used unsynchronised");
  reset_after_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(reset_request_out) |-> $past(state) == ST_RESET)
    else $error("reset request out of order");
  save_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_SAVE_WAIT && link.done && byte_idx == 6'(SAVE_BYTES - 1) |=> state == ST_RESET)
    else $error("save end not followed by reset");
  no_access_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reset_request_out |=> !ee_cs)
    else $error("EEPROM access during reset");
  motor_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reset_request_out |=> !feed_motor_hold_n)
    else $error("feed motor not held in reset");
  drop_alert_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_RECHECK && timer == 24'(RECHECK_CYCLES - 1) && !alert_s2 |=> state == ST_RUN)
    else $error("transient alert not ignored");
  cov_idle_c: cover property (@(posedge clk_sys) state == ST_RUN ##1 state == ST_SAVE);
  cov_recheck_c: cover property (@(posedge clk_sys) state == ST_RECHECK ##1 state == ST_RUN);
  cov_reset_c: cover property (@(posedge clk_sys) $rose(reset_request_out));
endmodule

/* hdl/pfail_pkg.sv */
// Package: constants and types for the power-fail save and reset block
// Assumes a 20 MHz system clock
package pfail_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int RECHECK_US = 10000;
  localparam int RECHECK_CYC = (CLK_HZ / 1000000) * RECHECK_US;
  localparam int SAVE_BYTES = 32;
  localparam int EE_ADDR_W = 7;
  localparam int EE_WORDS = 64;
  localparam int EE_CLK_DIV = 20;
  localparam int EE_OP_BITS = 3;
  localparam logic [2:0] EE_OP_WRITE = 3'h5;
  localparam int EE_FRAME_BITS = 25;
  localparam int EE_BUSY_CYC = 200000;
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_RECHECK = 6'h02,
    ST_SAVE = 6'h04,
    ST_SAVE_WAIT = 6'h08,
    ST_RESET = 6'h10,
    ST_HALT = 6'h20
  } pf_state_t;
endpackage

/* hdl/ee_link_if.sv */
// Interface: request and status between the sequencer and the EEPROM writer
// Assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface ee_link_if;
  logic start;
  logic [6:0] addr;
  logic [7:0] data;
  logic busy;
  logic done;
  modport master (output start, output addr, output data, input busy, input done);
  modport slave (input start, input addr, input data, output busy, output done);
endinterface

/* hdl/ee_writer.sv */
// Module: three-wire serial EEPROM byte writer
// Assumes the EEPROM signals ready on its data-out line after a write
`timescale 1ns/1ns
module ee_writer
  import pfail_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic inhibit,
  // Request side
  ee_link_if.slave link,
  // EEPROM pins
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic ee_do
);
  logic [4:0] div;
  logic tick;
  logic [5:0] bitn;
  logic [24:0] shreg;
  logic active;
  logic phase;
  logic ee_do_s1, ee_do_s2;

  // Serial clock enable divider
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !active) div <= '0;
    else if (div == 5'(EE_CLK_DIV - 1)) div <= '0;
    else div <= div + 5'h1;
  end
  assign tick = active && (div == 5'(EE_CLK_DIV - 1));

  // Ready line synchroniser
  always_ff @(posedge clk_sys) begin
    ee_do_s1 <= ee_do;
    ee_do_s2 <= ee_do_s1;
  end

  // Shift sequence; no access while inhibited
  always_ff @(posedge clk_sys) begin
    if (!rst_b || inhibit) begin
      active <= 1'b0;
      phase <= 1'b0;
      bitn <= '0;
      shreg <= '0;
      ee_cs <= 1'b0;
      ee_sk <= 1'b0;
      ee_di <= 1'b0;
      link.done <= 1'b0;
    end else begin
      link.done <= 1'b0;
      if (!active && link.start) begin
        active <= 1'b1;
        shreg <= {1'b1, 2'b01, link.addr[5:0], 8'h00, link.data};
        bitn <= '0;
        ee_cs <= 1'b1;
      end else if (tick) begin
        if (bitn < 6'(EE_FRAME_BITS)) begin
          ee_sk <= phase;
          if (!phase) begin
            ee_di <= shreg[24];
            shreg <= {shreg[23:0], 1'b0};
          end else bitn <= bitn + 6'h1;
          phase <= ~phase;
        end else if (bitn == 6'(EE_FRAME_BITS)) begin
          ee_cs <= 1'b0;
          ee_sk <= 1'b0;
          bitn <= bitn + 6'h1;
        end else if (!ee_cs) begin
          // Reselect first; data-out is only trusted one tick later
          ee_cs <= 1'b1;
        end else if (ee_do_s2) begin
          ee_cs <= 1'b0;
          active <= 1'b0;
          link.done <= 1'b1;
        end
      end
    end
  end
  assign link.busy = active;
endmodule

/* tb/ee_model.sv */
// Serial EEPROM stand-in: collects write frames, answers ready after a short busy time
// Assumes writer pins are registered on clk_sys
`timescale 1ns/1ns
module ee_model (
  // Clock
  input wire logic clk_sys,
  // Pins to and from the writer
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  output logic ee_do,
  // Observations
  output int frames,
  output int bits,
  output logic [2:0] head,
  output logic [5:0] last_addr,
  output logic [15:0] last_word
);
  logic cs_q = 0;
  logic sk_q = 0;
  logic [31:0] sr = 0;
  int n = 0;
  int busy = 0;
  logic flip = 0;
  initial frames = 0;
  initial bits = 0;
  initial head = 0;
  initial last_addr = 0;
  initial last_word = 0;
  // Shift in on clock rise, close frame on select fall
  always @(posedge clk_sys) begin
    cs_q <= ee_cs;
    sk_q <= ee_sk;
    flip <= ~flip;
    if (busy > 0) busy <= busy - 1;
    if (ee_cs && ee_sk && !sk_q) begin
      sr <= {sr[30:0], ee_di};
      n <= n + 1;
    end
    if (cs_q && !ee_cs && n > 2) begin
      frames <= frames + 1;
      bits <= n;
      head <= sr[n-1 -: 3];
      last_addr <= sr[21:16];
      last_word <= sr[15:0];
      busy <= 50;
    end
    if (!ee_cs) n <= 0;
  end
  // Ready when selected and idle; unselected output wanders
  assign ee_do = ee_cs ? (busy == 0) : flip;
endmodule

/* tb/power_fail_save_and_reset_bench.sv */
// Bench for the power-fail sequencer with an EEPROM stand-in
// Assumes a shortened recheck count and the package constants
`timescale 1ns/1ns
module power_fail_save_and_reset_bench;
  import pfail_pkg::*;
  localparam int RCY = 20;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic power_fail_alert = 0;
  logic printing = 0;
  logic [7:0] setting_data [SAVE_BYTES];
  logic reset_request_out, printing_stop, feed_motor_hold_n;
  logic ee_cs, ee_sk, ee_di, ee_do;
  int frames, bits, fails = 0, compares = 0, cyc = 0, f0;
  logic [2:0] head;
  logic [5:0] last_addr;
  logic [15:0] last_word;
  logic supply_switch_control = 1; // Open line leaves the supply on
  // Clock and run ceiling
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      wrap_up();
    end
  end
  pfail_seq #(.RECHECK_CYCLES(RCY), .SAVE_LIMIT_CYCLES(2000)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .power_fail_alert(power_fail_alert),
    .reset_request_out(reset_request_out), .printing_stop(printing_stop),
    .feed_motor_hold_n(feed_motor_hold_n), .printing(printing),
    .setting_data(setting_data), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
  ee_model eem (.clk_sys(clk_sys), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di),
    .ee_do(ee_do), .frames(frames), .bits(bits), .head(head),
    .last_addr(last_addr), .last_word(last_word));
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Supervisor reset held for four cycles, then released
  task automatic do_reset;
    @(negedge clk_sys);
    rst_b = 0;
    power_fail_alert = 0;
    printing = 0;
    supply_switch_control = 1;
    repeat (4) @(negedge clk_sys);
    chk("hold_n in reset", 0, feed_motor_hold_n);
    chk("cs in reset", 0, ee_cs);
    chk("req in reset", 0, reset_request_out);
    rst_b = 1;
    repeat (2) @(negedge clk_sys);
    chk("hold_n after reset", 1, feed_motor_hold_n);
    f0 = frames;
  endtask
  // Wait for the reset request, then judge the save and the aftermath
  task automatic finish_save;
    int k;
    k = 0;
    while (reset_request_out !== 1'b1 && k < 60000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("reset request", 1, reset_request_out);
    chk("frames saved", f0 + SAVE_BYTES, frames);
    chk("frame bits", EE_FRAME_BITS, bits);
    chk("frame op", EE_OP_WRITE, head);
    chk("last frame addr", SAVE_BYTES - 1, last_addr);
    chk("last frame word", {8'h00, setting_data[SAVE_BYTES-1]}, last_word);
    repeat (2) @(negedge clk_sys);
    chk("hold_n after request", 0, feed_motor_hold_n);
    repeat (100) @(negedge clk_sys);
    chk("cs after request", 0, ee_cs);
    chk("no later frames", f0 + SAVE_BYTES, frames);
  endtask
  // Idle alert saves at once, after the two-stage synchroniser
  task automatic idle_alert;
    do_reset();
    supply_switch_control = 0; // Panel switch grounds the line
    power_fail_alert = !supply_switch_control;
    repeat (2) @(negedge clk_sys);
    chk("cs before sync", 0, ee_cs);
    repeat (3) @(negedge clk_sys);
    chk("cs idle start", 1, ee_cs);
    finish_save();
  endtask
  // Alert gone by the recheck while printing is ignored
  task automatic print_glitch;
    do_reset();
    printing = 1;
    power_fail_alert = 1;
    repeat (4) @(negedge clk_sys);
    chk("print stop", 1, printing_stop);
    power_fail_alert = 0;
    repeat (RCY + 20) @(negedge clk_sys);
    chk("glitch req", 0, reset_request_out);
    chk("glitch frames", f0, frames);
    chk("stop sticky", 1, printing_stop);
  endtask
  // Alert held through the recheck while printing saves late
  task automatic print_held;
    do_reset();
    printing = 1;
    power_fail_alert = 1;
    repeat (RCY - 5) @(negedge clk_sys);
    chk("cs during recheck", 0, ee_cs);
    finish_save();
    chk("print stop held", 1, printing_stop);
  endtask
  initial begin
    for (int i = 0; i < SAVE_BYTES; i++) setting_data[i] = 8'(i * 7 + 8'h3C);
    idle_alert();
    print_glitch();
    print_held();
    wrap_up();
  end
endmodule
